// *** include/bsfeu_pkg.sv ***
// package of constants and types for the bit, shift and flag execution unit
`default_nettype none
package bsfeu_pkg;
    localparam int unsigned CORE_CLK_MHZ = 125;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned SP_W = 16;
    localparam int unsigned IO_ADDR_W = 6;
    localparam int unsigned WB_ADR_W = 4;

    // wishbone word offsets (byte addresses)
    localparam logic [3:0] FLAGS_OFS = 4'h0;
    localparam logic [3:0] SP_OFS = 4'h4;
    localparam logic [3:0] RESULT_OFS = 4'h8;
    localparam logic [3:0] STATE_OFS = 4'hC;

    // status flag bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [15:0] SP_STEP = 16'h0001;

    typedef enum logic [4:0] {
        NOP_OP = 5'h00,
        POP_OP = 5'h01,
        IO_BIT_SET_OP = 5'h02,
        IO_BIT_CLEAR_OP = 5'h03,
        SHIFT_LEFT_OP = 5'h04,
        SHIFT_RIGHT_OP = 5'h05,
        ROTATE_LEFT_CARRY_OP = 5'h06,
        ROTATE_RIGHT_CARRY_OP = 5'h07,
        ARITH_SHIFT_RIGHT_OP = 5'h08,
        NIBBLE_SWAP_OP = 5'h09,
        STATUS_BIT_SET_OP = 5'h0A,
        STATUS_BIT_CLEAR_OP = 5'h0B,
        BIT_TO_TRANSFER_FLAG_OP = 5'h0C,
        TRANSFER_FLAG_TO_BIT_OP = 5'h0D,
        CARRY_SET_OP = 5'h0E,
        CARRY_CLEAR_OP = 5'h0F,
        NEGATIVE_SET_OP = 5'h10,
        NEGATIVE_CLEAR_OP = 5'h11,
        ZERO_SET_OP = 5'h12,
        ZERO_CLEAR_OP = 5'h13,
        IRQ_GLOBAL_ON_OP = 5'h14,
        IRQ_GLOBAL_OFF_OP = 5'h15,
        SIGNED_SET_OP = 5'h16,
        SIGNED_CLEAR_OP = 5'h17,
        OVERFLOW_SET_OP = 5'h18,
        OVERFLOW_CLEAR_OP = 5'h19
    } bsfeu_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_POP = 2'b01,
        ST_IO_BIT = 2'b10
    } bsfeu_state_e;
endpackage
`default_nettype wire

// *** hw/bsfeu_core.sv ***
// execution unit for pop, i/o bit, shift, rotate, swap, transfer and flag instructions
// Operation
// - i/o bit set writes 1, clear writes 0
// - shift left: bits up, 0 in bit 0
// - shift right: bits down, 0 in bit 7
// - rotate left: carry in bit 0, bit 7 out
// - rotate right: carry in bit 7, bit 0 out
// - arithmetic shift right keeps bit 7
// - nibble swap, flags untouched
// - flag set/clear by operand, only that bit
// - bit store copies source bit to T
// - bit load copies T into destination bit
// - carry set and clear instructions
// - negative set and clear instructions
// - zero set and clear instructions
// - global interrupt enable and disable
// - signed flag set and clear instructions
// - pop loads destination from stack top
// - overflow set and clear instructions
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bsfeu_core
    import bsfeu_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic op_valid,
    input wire logic [4:0] op_code,
    input wire logic [2:0] op_sel,
    input wire logic [IO_ADDR_W-1:0] op_io_addr,
    input wire logic [DATA_W-1:0] src_value,
    input wire logic [DATA_W-1:0] io_rd_data,
    input wire logic [DATA_W-1:0] stack_rd_data,
    output logic busy,
    output logic op_done,
    output logic rd_we,
    output logic [DATA_W-1:0] rd_wdata,
    output logic io_rd_en,
    output logic io_we,
    output logic [IO_ADDR_W-1:0] io_addr,
    output logic [DATA_W-1:0] io_wdata,
    output logic stack_rd_en,
    output logic [SP_W-1:0] stack_addr,
    output logic [DATA_W-1:0] status_flags
);

    // maps a dedicated flag instruction to the flag it touches; even codes set, odd clear
    function automatic logic [2:0] flag_index(input logic [4:0] code);
        unique case (code)
            CARRY_SET_OP, CARRY_CLEAR_OP: flag_index = FLAG_C;
            NEGATIVE_SET_OP, NEGATIVE_CLEAR_OP: flag_index = FLAG_N;
            ZERO_SET_OP, ZERO_CLEAR_OP: flag_index = FLAG_Z;
            IRQ_GLOBAL_ON_OP, IRQ_GLOBAL_OFF_OP: flag_index = FLAG_I;
            SIGNED_SET_OP, SIGNED_CLEAR_OP: flag_index = FLAG_S;
            default: flag_index = FLAG_V;
        endcase
    endfunction

    // write a byte lane into a stored field when its select bit is high
    function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                        input logic en);
        lane = en ? nw : old;
    endfunction

    bsfeu_state_e state_reg, state_next;
    logic [7:0] flags_reg, flags_next;
    logic [SP_W-1:0] sp_reg, sp_next;
    logic [7:0] result_reg, result_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic rd_we_reg, rd_we_next;
    logic io_rd_en_reg, io_rd_en_next;
    logic io_we_reg, io_we_next;
    logic [IO_ADDR_W-1:0] io_addr_reg, io_addr_next;
    logic [7:0] io_wdata_reg, io_wdata_next;
    logic stack_rd_en_reg, stack_rd_en_next;
    logic [SP_W-1:0] stack_addr_reg, stack_addr_next;
    logic [2:0] sel_reg, sel_next;
    logic io_set_reg, io_set_next;
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;

    logic bus_req;
    logic bus_wr;
    logic [7:0] shift_val;
    logic shift_carry;
    logic shift_op;

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign bus_wr = bus_req & wb_we_i;

    // shifter shared by the five shift and rotate instructions
    always_comb
    begin
        shift_op = 1'b1;
        shift_val = src_value;
        shift_carry = flags_reg[FLAG_C];
        unique case (op_code)
            SHIFT_LEFT_OP:
            begin
                shift_val = {src_value[6:0], 1'b0};
                shift_carry = src_value[7];
            end
            SHIFT_RIGHT_OP:
            begin
                shift_val = {1'b0, src_value[7:1]};
                shift_carry = src_value[0];
            end
            ROTATE_LEFT_CARRY_OP:
            begin
                shift_val = {src_value[6:0], flags_reg[FLAG_C]};
                shift_carry = src_value[7];
            end
            ROTATE_RIGHT_CARRY_OP:
            begin
                shift_val = {flags_reg[FLAG_C], src_value[7:1]};
                shift_carry = src_value[0];
            end
            ARITH_SHIFT_RIGHT_OP:
            begin
                shift_val = {src_value[7], src_value[7:1]};
                shift_carry = src_value[0];
            end
            default: shift_op = 1'b0;
        endcase
    end

    // instruction sequencing and status flags
    always_comb
    begin
        state_next = state_reg;
        flags_next = flags_reg;
        sp_next = sp_reg;
        result_next = result_reg;
        busy_next = 1'b0;
        done_next = 1'b0;
        rd_we_next = 1'b0;
        io_rd_en_next = 1'b0;
        io_we_next = 1'b0;
        io_addr_next = io_addr_reg;
        io_wdata_next = io_wdata_reg;
        stack_rd_en_next = 1'b0;
        stack_addr_next = stack_addr_reg;
        sel_next = sel_reg;
        io_set_next = io_set_reg;

        // software writes first so a same-cycle instruction overrides them
        if (bus_wr && wb_adr_i == FLAGS_OFS)
        begin
            flags_next = lane(flags_reg, wb_dat_i[7:0], wb_sel_i[0]);
        end
        if (bus_wr && wb_adr_i == SP_OFS)
        begin
            sp_next[7:0] = lane(sp_reg[7:0], wb_dat_i[7:0], wb_sel_i[0]);
            sp_next[15:8] = lane(sp_reg[15:8], wb_dat_i[15:8], wb_sel_i[1]);
        end

        unique case (state_reg)
            ST_IDLE:
            begin
                if (op_valid)
                begin
                    if (shift_op)
                    begin
                        result_next = shift_val;
                        rd_we_next = 1'b1;
                        done_next = 1'b1;
                        flags_next[FLAG_C] = shift_carry;
                        flags_next[FLAG_Z] = (shift_val == ZERO_BYTE);
                        flags_next[FLAG_N] = shift_val[7];
                        flags_next[FLAG_V] = shift_val[7] ^ shift_carry;
                    end
                    else
                    begin
                        unique case (op_code)
                            POP_OP:
                            begin
                                sp_next = sp_reg + SP_STEP;
                                stack_addr_next = sp_reg + SP_STEP;
                                stack_rd_en_next = 1'b1;
                                busy_next = 1'b1;
                                state_next = ST_POP;
                            end
                            IO_BIT_SET_OP, IO_BIT_CLEAR_OP:
                            begin
                                io_addr_next = op_io_addr;
                                io_rd_en_next = 1'b1;
                                sel_next = op_sel;
                                io_set_next = (op_code == IO_BIT_SET_OP);
                                busy_next = 1'b1;
                                state_next = ST_IO_BIT;
                            end
                            NIBBLE_SWAP_OP:
                            begin
                                result_next = {src_value[3:0], src_value[7:4]};
                                rd_we_next = 1'b1;
                                done_next = 1'b1;
                            end
                            STATUS_BIT_SET_OP, STATUS_BIT_CLEAR_OP:
                            begin
                                flags_next[op_sel] = (op_code == STATUS_BIT_SET_OP);
                                done_next = 1'b1;
                            end
                            BIT_TO_TRANSFER_FLAG_OP:
                            begin
                                flags_next[FLAG_T] = src_value[op_sel];
                                done_next = 1'b1;
                            end
                            TRANSFER_FLAG_TO_BIT_OP:
                            begin
                                result_next = src_value;
                                result_next[op_sel] = flags_reg[FLAG_T];
                                rd_we_next = 1'b1;
                                done_next = 1'b1;
                            end
                            CARRY_SET_OP, CARRY_CLEAR_OP,
                            NEGATIVE_SET_OP, NEGATIVE_CLEAR_OP,
                            ZERO_SET_OP, ZERO_CLEAR_OP,
                            IRQ_GLOBAL_ON_OP, IRQ_GLOBAL_OFF_OP,
                            SIGNED_SET_OP, SIGNED_CLEAR_OP,
                            OVERFLOW_SET_OP, OVERFLOW_CLEAR_OP:
                            begin
                                flags_next[flag_index(op_code)] = ~op_code[0];
                                done_next = 1'b1;
                            end
                            default: done_next = 1'b1; // unknown codes retire as a no-operation
                        endcase
                    end
                end
            end
            ST_POP:
            begin
                result_next = stack_rd_data;
                rd_we_next = 1'b1;
                done_next = 1'b1;
                state_next = ST_IDLE;
            end
            ST_IO_BIT:
            begin
                io_wdata_next = io_rd_data;
                io_wdata_next[sel_reg] = io_set_reg;
                io_we_next = 1'b1;
                done_next = 1'b1;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // wishbone slave: one wait state, unmapped reads give zero
    always_comb
    begin
        ack_next = bus_req;
        dat_next = 32'h0000_0000;
        if (bus_req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                FLAGS_OFS: dat_next = {24'h00_0000, flags_reg};
                SP_OFS: dat_next = {16'h0000, sp_reg};
                RESULT_OFS: dat_next = {24'h00_0000, result_reg};
                STATE_OFS: dat_next = {29'h0000_0000, busy_reg, state_reg};
                default: dat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= ST_IDLE;
            flags_reg <= FLAGS_RST;
            sp_reg <= SP_RST;
            result_reg <= ZERO_BYTE;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            rd_we_reg <= 1'b0;
            io_rd_en_reg <= 1'b0;
            io_we_reg <= 1'b0;
            io_addr_reg <= '0;
            io_wdata_reg <= ZERO_BYTE;
            stack_rd_en_reg <= 1'b0;
            stack_addr_reg <= SP_RST;
            sel_reg <= 3'h0;
            io_set_reg <= 1'b0;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            flags_reg <= flags_next;
            sp_reg <= sp_next;
            result_reg <= result_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            rd_we_reg <= rd_we_next;
            io_rd_en_reg <= io_rd_en_next;
            io_we_reg <= io_we_next;
            io_addr_reg <= io_addr_next;
            io_wdata_reg <= io_wdata_next;
            stack_rd_en_reg <= stack_rd_en_next;
            stack_addr_reg <= stack_addr_next;
            sel_reg <= sel_next;
            io_set_reg <= io_set_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;
    assign busy = busy_reg;
    assign op_done = done_reg;
    assign rd_we = rd_we_reg;
    assign rd_wdata = result_reg;
    assign io_rd_en = io_rd_en_reg;
    assign io_we = io_we_reg;
    assign io_addr = io_addr_reg;
    assign io_wdata = io_wdata_reg;
    assign stack_rd_en = stack_rd_en_reg;
    assign stack_addr = stack_addr_reg;
    assign status_flags = flags_reg;

endmodule
`default_nettype wire

// *** test/bsfeu_core_sva.sv ***
// concurrent checks on the execution unit ports
`timescale 1ns/1ps
`default_nettype none
module bsfeu_core_sva
    import bsfeu_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic op_valid,
    input wire logic [4:0] op_code,
    input wire logic [2:0] op_sel,
    input wire logic [IO_ADDR_W-1:0] op_io_addr,
    input wire logic [DATA_W-1:0] src_value,
    input wire logic [DATA_W-1:0] io_rd_data,
    input wire logic [DATA_W-1:0] stack_rd_data,
    input wire logic busy,
    input wire logic op_done,
    input wire logic rd_we,
    input wire logic [DATA_W-1:0] rd_wdata,
    input wire logic io_rd_en,
    input wire logic io_we,
    input wire logic [IO_ADDR_W-1:0] io_addr,
    input wire logic [DATA_W-1:0] io_wdata,
    input wire logic stack_rd_en,
    input wire logic [DATA_W-1:0] status_flags
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_take(logic [4:0] c);
        op_valid && !busy && op_code == c;
    endsequence
    sequence s_rmw;
        io_rd_en && io_addr == $past(op_io_addr) ##1 io_we;
    endsequence
    // ack must drop on its own so a held request is not taken twice
    ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse");
    one_cycle_a: assert property (op_valid && !busy &&
        !(op_code inside {POP_OP, IO_BIT_SET_OP, IO_BIT_CLEAR_OP}) |=> op_done && !busy)
        else $error("single cycle op late");
    two_cycle_a: assert property (op_valid && !busy &&
        op_code inside {POP_OP, IO_BIT_SET_OP, IO_BIT_CLEAR_OP}
        |=> busy && !op_done ##1 op_done && !busy) else $error("two cycle op timing");
    pop_load_a: assert property (s_take(POP_OP) |=> stack_rd_en ##1 rd_we &&
        rd_wdata == $past(stack_rd_data) && status_flags == $past(status_flags, 2))
        else $error("pop result wrong");
    io_set_a: assert property (s_take(IO_BIT_SET_OP) |=> s_rmw ##0
        io_wdata == ($past(io_rd_data) | (8'h01 << $past(op_sel, 2)))) else $error("io set wrong");
    io_clear_a: assert property (s_take(IO_BIT_CLEAR_OP) |=> s_rmw ##0
        io_wdata == ($past(io_rd_data) & ~(8'h01 << $past(op_sel, 2))))
        else $error("io clear wrong");
    shl_value_a: assert property (s_take(SHIFT_LEFT_OP) |=> rd_we &&
        rd_wdata == {$past(src_value[6:0]), 1'b0} && status_flags[0] == $past(src_value[7]))
        else $error("shift left wrong");
    asr_value_a: assert property (s_take(ARITH_SHIFT_RIGHT_OP) |=>
        rd_wdata == {$past(src_value[7]), $past(src_value[7:1])}) else $error("asr wrong");
    swap_value_a: assert property (s_take(NIBBLE_SWAP_OP) |=> $stable(status_flags) &&
        rd_wdata == {$past(src_value[3:0]), $past(src_value[7:4])}) else $error("swap wrong");
    bit_store_a: assert property (s_take(BIT_TO_TRANSFER_FLAG_OP) |=>
        status_flags[6] == |(($past(src_value) >> $past(op_sel)) & 8'h01))
        else $error("bit store wrong");
endmodule
bind bsfeu_core bsfeu_core_sva bsfeu_core_sva_i (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .op_valid, .op_code, .op_sel, .op_io_addr, .src_value, .io_rd_data,
    .stack_rd_data, .busy, .op_done, .rd_we, .rd_wdata, .io_rd_en, .io_we, .io_addr,
    .io_wdata, .stack_rd_en, .status_flags);
`default_nettype wire

// *** test/bsfeu_mem_model.sv ***
// i/o space and stack memory facing the execution unit
`timescale 1ns/1ps
`default_nettype none
module bsfeu_mem_model
    import bsfeu_pkg::*;
(
    input wire logic core_clk,
    input wire logic io_rd_en,
    input wire logic io_we,
    input wire logic [IO_ADDR_W-1:0] io_addr,
    input wire logic [DATA_W-1:0] io_wdata,
    input wire logic stack_rd_en,
    input wire logic [SP_W-1:0] stack_addr,
    output logic [DATA_W-1:0] io_rd_data,
    output logic [DATA_W-1:0] stack_rd_data
);
    logic [7:0] io_mem [64];
    logic [7:0] io_last = 8'h00;
    logic [7:0] stk_last = 8'h00;
    initial for (int i = 0; i < 64; i++) io_mem[i] = {2'b10, 6'(i)};
    always @(posedge core_clk)
    begin
        if (io_we) io_mem[io_addr] <= io_wdata;
        if (io_rd_en) io_last <= io_rd_data;
        if (stack_rd_en) stk_last <= stack_rd_data;
    end
    // unread lines show the inverse so a late sample cannot pass by luck
    always_comb io_rd_data = io_rd_en ? io_mem[io_addr] : ~io_last;
    always_comb stack_rd_data = stack_rd_en ? (stack_addr[7:0] ^ 8'h5A) : ~stk_last;
endmodule
`default_nettype wire

// *** test/tb_bit_shift_flag_exec_unit.sv ***
// self-checking bench for the bit, shift and flag execution unit
`timescale 1ns/1ps
`default_nettype none
module tb_bit_shift_flag_exec_unit
    import bsfeu_pkg::*;
;
    localparam logic [2:0] FB [6] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V};
    localparam logic [7:0] TV [4] = '{8'h81, 8'h00, 8'h40, 8'hFE};
    localparam logic [3:0] IOT [3] = '{4'h3, 4'hF, 4'h8};
    logic core_clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic op_valid = 1'b0, wb_ack_o, busy, op_done, rd_we, io_rd_en, io_we, stack_rd_en;
    logic [4:0] op_code = 5'h00;
    logic [2:0] op_sel = 3'h0;
    logic [5:0] op_io_addr = 6'h00, io_addr;
    logic [7:0] src_value = 8'h00, io_rd_data, stack_rd_data, rd_wdata, io_wdata;
    logic [7:0] status_flags, fl, iv;
    logic [15:0] stack_addr, e;
    int n_mismatch = 0, checked = 0;
    bsfeu_core bsfeu_core_i (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .op_valid, .op_code, .op_sel, .op_io_addr,
        .src_value, .io_rd_data, .stack_rd_data, .busy, .op_done, .rd_we, .rd_wdata,
        .io_rd_en, .io_we, .io_addr, .io_wdata, .stack_rd_en, .stack_addr, .status_flags);
    bsfeu_mem_model bsfeu_mem_model_i (.core_clk, .io_rd_en, .io_we, .io_addr, .io_wdata,
        .stack_rd_en, .stack_addr, .io_rd_data, .stack_rd_data);
    always #4 core_clk = ~core_clk;
    task automatic end_of_test();
        if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        checked++;
        if (got !== ex)
        begin
            $display("BAD %s expected %h seen %h", nm, ex, got);
            n_mismatch++;
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
        input logic [31:0] d);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        // no cycle count is assumed; only the watchdog ends a hung wait
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic op(input logic [4:0] c, input logic [2:0] s, input logic [5:0] p,
        input logic [7:0] v);
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= c;
        op_sel <= s;
        op_io_addr <= p;
        src_value <= v;
        // held until an idle edge takes it, then waited on until it retires
        do @(posedge core_clk); while (busy !== 1'b0);
        op_valid <= 1'b0;
        do @(posedge core_clk); while (op_done !== 1'b1);
    endtask
    function automatic logic [15:0] ref_exec(input logic [4:0] c, input logic [2:0] s,
        input logic [7:0] v, input logic [7:0] f);
        logic [7:0] r;
        logic cy;
        r = v;
        cy = f[0];
        case (c)
            5'h04: {cy, r} = {v, 1'b0};
            5'h05: {r, cy} = {1'b0, v};
            5'h06: {cy, r} = {v, f[0]};
            5'h07: {r, cy} = {f[0], v};
            5'h08: {r, cy} = {v[7], v};
            5'h09: r = {v[3:0], v[7:4]};
            5'h0A: f[s] = 1'b1;
            5'h0B: f[s] = 1'b0;
            5'h0C: f[FLAG_T] = v[s];
            5'h0D: r[s] = f[FLAG_T];
            default: f[FB[(c - 5'h0E) >> 1]] = ~c[0];
        endcase
        // shifts refresh V N Z C only, S and H are left alone
        if (c inside {[5'h04:5'h08]}) f[3:0] = {r[7] ^ cy, r[7], r == 8'h00, cy};
        return {f, r};
    endfunction
    initial
    begin
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        wb(1'b0, FLAGS_OFS, 4'hF, 32'h0);
        chk("flags_reset", 16'(FLAGS_RST), rd[15:0]);
        wb(1'b0, 4'h2, 4'hF, 32'h0);
        chk("unmapped", 16'h0000, rd[15:0]);
        wb(1'b1, FLAGS_OFS, 4'h1, 32'h0000_0081);
        fl = 8'h81;
        foreach (TV[k])
            for (logic [4:0] c = 5'h04; c <= 5'h19; c++)
            begin
                op(c, c[2:0] ^ TV[k][2:0], 6'h00, TV[k]);
                e = ref_exec(c, c[2:0] ^ TV[k][2:0], TV[k], fl);
                fl = e[15:8];
                if (c < CARRY_SET_OP)
                    chk("flags", 16'(fl), 16'(status_flags));
                else if (c < IRQ_GLOBAL_ON_OP)
                    chk("flags_czn", 16'(fl), 16'(status_flags));
                else
                    chk("flags_isv", 16'(fl), 16'(status_flags));
                if (c inside {[5'h04:5'h07]})
                    chk("shift", 16'(e[7:0]), 16'(rd_wdata));
                else if (c inside {[5'h08:5'h09], 5'h0D})
                    chk("result", 16'(e[7:0]), 16'(rd_wdata));
            end
        // low byte wraps so the high byte must take the carry
        wb(1'b1, SP_OFS, 4'h3, 32'h0000_00FF);
        for (int k = 0; k < 2; k++)
        begin
            op(POP_OP, 3'h0, 6'h00, 8'h00);
            chk("stack_addr", 16'h0100 + 16'(k), stack_addr);
            chk("pop_data", 16'(8'h5A ^ 8'(k)), 16'(rd_wdata));
        end
        wb(1'b0, SP_OFS, 4'hF, 32'h0);
        chk("stack_ptr", 16'h0101, rd[15:0]);
        wb(1'b0, RESULT_OFS, 4'hF, 32'h0);
        chk("result_reg", 16'h005B, rd[15:0]);
        wb(1'b0, STATE_OFS, 4'hF, 32'h0);
        chk("state_reg", 16'h0000, rd[15:0]);
        iv = 8'h95;
        foreach (IOT[k])
        begin
            op(IOT[k][3] ? IO_BIT_CLEAR_OP : IO_BIT_SET_OP, IOT[k][2:0], 6'h15, 8'h00);
            iv[IOT[k][2:0]] = ~IOT[k][3];
            chk("io_wdata", 16'(iv), 16'(io_wdata));
            chk("io_addr", 16'h0015, 16'(io_addr));
        end
        chk("flags_kept", 16'(fl), 16'(status_flags));
        end_of_test();
    end
    initial
    begin
        repeat (3000) @(posedge core_clk);
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
